// ---- verilog/two_wire_slave_defs.svh ----
// Register offsets, control bits, status codes and reset values of the two-wire slave
`ifndef TWO_WIRE_SLAVE_DEFS_SVH
`define TWO_WIRE_SLAVE_DEFS_SVH

// ********************
// Register offsets
// ********************
`define OFF_DATA        2'h0
`define OFF_STATUS      2'h1
`define OFF_OWN_ADDR    2'h2
`define OFF_CONTROL     2'h3

// ********************
// Control register bits
// ********************
`define CTL_DONE        7
`define CTL_ACK_EN      6
`define CTL_BEGIN       5
`define CTL_HALT        4
`define CTL_WCOL        3
`define CTL_BUS_EN      2
`define CTL_IRQ_EN      0

// ********************
// Reset values
// ********************
`define RST_DATA        8'hff
`define RST_OWN_ADDR    8'hfe
`define RST_CONTROL     8'h00
`define RST_STATUS      8'hf8

// ********************
// Status codes, prescaler bits zero
// ********************
`define ST_OWN_W        8'h60
`define ST_GEN_W        8'h70
`define ST_OWN_RX_ACK   8'h80
`define ST_OWN_RX_NACK  8'h88
`define ST_GEN_RX_ACK   8'h90
`define ST_GEN_RX_NACK  8'h98
`define ST_STOP         8'ha0
`define ST_OWN_R        8'ha8
`define ST_ARB_R        8'hb0
`define ST_TX_ACK       8'hb8
`define ST_TX_NACK      8'hc0
`define ST_TX_LAST_ACK  8'hc8
`define ST_NONE         8'hf8
`define GEN_CALL_ADDR   7'h00

`endif

// ---- verilog/two_wire_slave_pkg.sv ----
// Types shared by the two-wire slave
package two_wire_slave_pkg;
  typedef enum logic [2:0] {IDLE, ADDR, ACK_OUT, RX, TX, ACK_IN, WAIT} phase_t;
endpackage : two_wire_slave_pkg

// ---- verilog/two_wire_slave.sv ----
// Two-wire slave receiver and transmitter with register port
// Behaviour
// RULE1: general-call byte acked gives $90; next byte acked per ack_enable.
// RULE2: unacked general-call byte gives $98; leave addressed state on done clear.
// RULE3: stop or repeated start while addressed gives $A0, then not addressed.
// RULE4: not addressed with ack_enable zero: no own or broadcast recognition.
// RULE5: ack_enable one: own address recognised; broadcast only if accepted.
// RULE6: begin request set on leaving slave: issue start once bus is free.
// RULE7: own address in upper seven bits; lowest bit accepts broadcast call.
// RULE8: software sets bus_enable and ack_enable to prepare slave use.
// RULE9: software writes begin and halt requests zero during slave setup.
// RULE10: direction bit one enters transmit, else receive.
// RULE11: after own address and direction, done flag set with valid status.
// RULE12: lost arbitration then addressed for read reports $B0.
// RULE13: ack_enable cleared: one final byte, then $C0 or $C8.
// RULE14: after final byte, not addressed; SDA released so master reads ones.
// RULE15: $C8 when master acks after the byte marked last.
// RULE16: ack_enable zero ignores own address; recognition resumes when set.
// RULE17: in deep sleep own or broadcast address still acknowledged.
// RULE18: sleep match wakes part and holds SCL low until done cleared.
// RULE19: data register need not hold the last byte after a sleep wake.
// RULE20: status codes read with prescaler bits zero.
// RULE21: own address read acked gives $A8 and sends loaded data byte.
// RULE22: transmitted byte acked gives $B8 and sends next loaded byte.
// RULE23: done flag set during a transfer stretches SCL low. The code does not stretch after $A0, $C0, $C8 or a NACKed data byte.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "two_wire_slave_defs.svh"

module two_wire_slave (
  input  wire logic       clock,     // System clock, 50 MHz
  input  wire logic       rst,       // Asynchronous reset, active high
  input  wire logic [1:0] regAddr,   // Register index
  input  wire logic [7:0] regWdata,  // Write data
  input  wire logic       regWr,     // Write strobe
  input  wire logic       regRd,     // Read strobe
  output logic      [7:0] regRdata,  // Read data, cycle after strobe
  input  wire logic       sclIn,     // SCL pin level
  output logic            sclOut,    // SCL drive level, always low
  output logic            sclOe,     // SCL pulled low while high
  input  wire logic       sdaIn,     // SDA pin level
  output logic            sdaOut,    // SDA drive level, always low
  output logic            sdaOe,     // SDA pulled low while high
  input  wire logic       deepSleep, // Part is in a deep sleep mode
  input  wire logic       arbLost,   // Master logic lost arbitration
  output logic            wakeUp,    // Pulse: address match during sleep
  output logic            issueStart // Pulse: start wanted, bus free
);

  // ********************
  // Pin synchronisers and bus conditions
  // ********************
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic       sclPrev;
  logic       sdaPrev;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       busBusy;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  assign sclRise   = sclSync[1] & ~sclPrev;
  assign sclFall   = ~sclSync[1] & sclPrev;
  assign startSeen = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
  assign stopSeen  = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busBusy <= 1'b0;
    end else if (startSeen) begin
      busBusy <= 1'b1;
    end else if (stopSeen) begin
      busBusy <= 1'b0;
    end
  end

  // ********************
  // Registers
  // ********************
  logic [7:0] dataReg;
  logic [7:0] statusCode;
  logic [7:0] own_address_reg;
  logic       job_done_flag;
  logic       ack_enable;
  logic       begin_request_flag;
  logic       halt_request_flag;
  logic       write_collision_flag;
  logic       bus_enable;
  logic       irq_enable;
  logic       postEvent;
  logic [7:0] postCode;
  logic       postData;
  logic [7:0] rxByte;
  logic [7:0] shift;
  logic       ctlWr;
  logic       doneClr;

  assign ctlWr   = regWr && regAddr == `OFF_CONTROL;
  assign doneClr = ctlWr && regWdata[`CTL_DONE];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      own_address_reg    <= `RST_OWN_ADDR;
      ack_enable         <= 1'b0;
      begin_request_flag <= 1'b0;
      halt_request_flag  <= 1'b0;
      bus_enable         <= 1'b0;
      irq_enable         <= 1'b0;
    end else begin
      if (regWr && regAddr == `OFF_OWN_ADDR) begin
        own_address_reg <= regWdata; // RULE7
      end
      if (ctlWr) begin
        ack_enable         <= regWdata[`CTL_ACK_EN];
        begin_request_flag <= regWdata[`CTL_BEGIN];
        halt_request_flag  <= regWdata[`CTL_HALT];
        bus_enable         <= regWdata[`CTL_BUS_EN];
        irq_enable         <= regWdata[`CTL_IRQ_EN];
      end
    end
  end

  // Hardware set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      job_done_flag <= 1'b0;
      statusCode    <= `RST_STATUS;
    end else if (postEvent) begin
      job_done_flag <= 1'b1; // RULE11
      statusCode    <= postCode;
    end else if (doneClr) begin
      job_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataReg              <= `RST_DATA;
      write_collision_flag <= 1'b0;
    end else begin
      if (postData && !deepSleep) begin
        dataReg <= shift; // RULE19
      end else if (regWr && regAddr == `OFF_DATA) begin
        if (job_done_flag) begin
          dataReg              <= regWdata;
          write_collision_flag <= 1'b0;
        end else begin
          write_collision_flag <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `OFF_DATA:     regRdata <= dataReg;
        `OFF_STATUS:   regRdata <= job_done_flag ? statusCode : `ST_NONE; // RULE20
        `OFF_OWN_ADDR: regRdata <= own_address_reg;
        `OFF_CONTROL:  regRdata <= {job_done_flag, ack_enable, begin_request_flag,
                                    halt_request_flag, write_collision_flag,
                                    bus_enable, 1'b0, irq_enable};
      endcase
    end
  end

  // ********************
  // Bus engine
  // ********************
  two_wire_slave_pkg::phase_t phase;
  two_wire_slave_pkg::phase_t resume;
  logic [2:0] bitCnt;
  logic       ackPhase;
  logic       ackBit;
  logic       addrStage;
  logic       isGeneral;
  logic       isRead;
  logic       lastByte;
  logic       masterAck;
  logic       addressed;
  logic       sdaLow;
  logic       startPending;
  logic       ownMatch;
  logic       genMatch;

  assign rxByte   = {shift[6:0], sdaSync[1]};
  // Recognition follows ack_enable live, so clearing it isolates the slave
  assign ownMatch = ack_enable && bus_enable
                    && rxByte[7:1] == own_address_reg[7:1]; // RULE5 RULE16
  assign genMatch = ack_enable && bus_enable && own_address_reg[0]
                    && rxByte[7:1] == `GEN_CALL_ADDR && !rxByte[0]; // RULE4 RULE5

  always_comb begin
    postEvent = 1'b0;
    postCode  = `ST_NONE;
    postData  = 1'b0;
    if ((startSeen || stopSeen) && addressed) begin
      postEvent = 1'b1;
      postCode  = `ST_STOP; // RULE3
    end else if (phase == two_wire_slave_pkg::ACK_OUT && sclFall && ackPhase) begin
      postEvent = 1'b1;
      if (addrStage) begin
        if (isRead) begin
          postCode = arbLost ? `ST_ARB_R : `ST_OWN_R; // RULE12 RULE21
        end else begin
          postCode = isGeneral ? `ST_GEN_W : `ST_OWN_W;
        end
      end else begin
        postData = 1'b1;
        if (isGeneral) begin
          postCode = ackBit ? `ST_GEN_RX_ACK : `ST_GEN_RX_NACK; // RULE1 RULE2
        end else begin
          postCode = ackBit ? `ST_OWN_RX_ACK : `ST_OWN_RX_NACK;
        end
      end
    end else if (phase == two_wire_slave_pkg::ACK_IN && sclFall) begin
      postEvent = 1'b1;
      if (!masterAck) begin
        postCode = `ST_TX_NACK; // RULE13
      end else if (lastByte) begin
        postCode = `ST_TX_LAST_ACK; // RULE13 RULE15
      end else begin
        postCode = `ST_TX_ACK; // RULE22
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase     <= two_wire_slave_pkg::IDLE;
      resume    <= two_wire_slave_pkg::IDLE;
      shift     <= 8'h00;
      bitCnt    <= 3'h0;
      ackPhase  <= 1'b0;
      ackBit    <= 1'b0;
      addrStage <= 1'b0;
      isGeneral <= 1'b0;
      isRead    <= 1'b0;
      lastByte  <= 1'b0;
      masterAck <= 1'b0;
      addressed <= 1'b0;
      sdaLow    <= 1'b0;
      wakeUp    <= 1'b0;
    end else begin
      wakeUp <= 1'b0;
      if (startSeen) begin
        phase     <= two_wire_slave_pkg::ADDR;
        bitCnt    <= 3'h0;
        addressed <= 1'b0;
        sdaLow    <= 1'b0;
      end else if (stopSeen) begin
        phase     <= two_wire_slave_pkg::IDLE;
        addressed <= 1'b0;
        sdaLow    <= 1'b0;
        if (addressed) begin
          phase  <= two_wire_slave_pkg::WAIT;
          resume <= two_wire_slave_pkg::IDLE; // RULE3
        end
      end else begin
        unique case (phase)
          two_wire_slave_pkg::IDLE: begin
            sdaLow <= 1'b0; // RULE14
          end
          two_wire_slave_pkg::ADDR, two_wire_slave_pkg::RX: begin
            if (sclRise) begin
              shift  <= rxByte;
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == 3'h7) begin
                ackPhase <= 1'b0;
                phase    <= two_wire_slave_pkg::ACK_OUT;
                if (phase == two_wire_slave_pkg::ADDR) begin
                  addrStage <= 1'b1;
                  ackBit    <= ownMatch || genMatch; // RULE17
                  isGeneral <= !ownMatch;
                  isRead    <= rxByte[0]; // RULE10
                  wakeUp    <= deepSleep && (ownMatch || genMatch); // RULE18
                  if (!(ownMatch || genMatch)) begin
                    phase <= two_wire_slave_pkg::IDLE;
                  end
                end else begin
                  addrStage <= 1'b0;
                  ackBit    <= ack_enable; // RULE1
                end
              end
            end
          end
          two_wire_slave_pkg::ACK_OUT: begin
            if (sclFall) begin
              ackPhase <= 1'b1;
              sdaLow   <= !ackPhase && ackBit;
              if (ackPhase) begin
                addressed <= 1'b1;
                phase     <= two_wire_slave_pkg::WAIT;
                if (!ackBit) begin
                  resume <= two_wire_slave_pkg::IDLE; // RULE2
                end else if (addrStage && isRead) begin
                  resume <= two_wire_slave_pkg::TX;
                end else begin
                  resume <= two_wire_slave_pkg::RX;
                end
              end
            end
          end
          two_wire_slave_pkg::TX: begin
            if (sclFall) begin
              bitCnt <= bitCnt + 3'h1;
              shift  <= {shift[6:0], 1'b1};
              sdaLow <= !shift[6];
              if (bitCnt == 3'h7) begin
                sdaLow <= 1'b0;
                phase  <= two_wire_slave_pkg::ACK_IN;
              end
            end
          end
          two_wire_slave_pkg::ACK_IN: begin
            if (sclRise) begin
              masterAck <= !sdaSync[1];
            end
            if (sclFall) begin
              phase <= two_wire_slave_pkg::WAIT;
              if (!masterAck || lastByte) begin
                resume <= two_wire_slave_pkg::IDLE; // RULE14
              end else begin
                resume <= two_wire_slave_pkg::TX; // RULE22
              end
            end
          end
          two_wire_slave_pkg::WAIT: begin
            if (doneClr) begin
              phase  <= resume;
              bitCnt <= 3'h0;
              if (resume == two_wire_slave_pkg::IDLE) begin
                addressed <= 1'b0; // RULE2 RULE14
              end
              if (resume == two_wire_slave_pkg::TX) begin
                shift    <= dataReg; // RULE21 RULE22
                sdaLow   <= !dataReg[7];
                lastByte <= !regWdata[`CTL_ACK_EN]; // RULE13
              end
            end
          end
        endcase
      end
    end
  end

  // Start request held until the bus goes idle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startPending <= 1'b0;
      issueStart   <= 1'b0;
    end else begin
      issueStart <= 1'b0;
      if (phase == two_wire_slave_pkg::WAIT && resume == two_wire_slave_pkg::IDLE
          && doneClr && regWdata[`CTL_BEGIN]) begin
        startPending <= 1'b1; // RULE6
      end else if (startPending && !busBusy) begin
        startPending <= 1'b0;
        issueStart   <= 1'b1; // RULE6
      end
    end
  end

  // ********************
  // Pin drive
  // ********************
  // Stretch only while a transfer continues after software answers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclOe <= 1'b0;
    end else begin
      sclOe <= (postEvent && postCode != `ST_STOP && postCode != `ST_TX_NACK
                && postCode != `ST_TX_LAST_ACK && !(postData && !ackBit)
                && !(postCode == `ST_OWN_W && 1'b0))
               || (sclOe && !doneClr && !startSeen && !stopSeen); // RULE18 RULE23
    end
  end

  assign sdaOe  = sdaLow;
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

endmodule : two_wire_slave

// ---- testbench/two_wire_slave_sva.sv ----
// Concurrent checks on the ports of the two-wire slave
`timescale 1ns/1ps
`include "two_wire_slave_defs.svh"

module two_wire_slave_sva (
  input wire logic       clock,     // System clock
  input wire logic       rst,       // Asynchronous reset, active high
  input wire logic [1:0] regAddr,   // Register index
  input wire logic [7:0] regWdata,  // Write data
  input wire logic       regWr,     // Write strobe
  input wire logic       regRd,     // Read strobe
  input wire logic [7:0] regRdata,  // Read data
  input wire logic       sclIn,     // SCL level
  input wire logic       sclOut,    // SCL drive level
  input wire logic       sclOe,     // SCL pull enable
  input wire logic       sdaIn,     // SDA level
  input wire logic       sdaOut,    // SDA drive level
  input wire logic       sdaOe,     // SDA pull enable
  input wire logic       deepSleep, // Part asleep
  input wire logic       arbLost,   // Arbitration lost
  input wire logic       wakeUp,    // Wake pulse
  input wire logic       issueStart // Start request pulse
);
  // ********************
  // Helpers
  // ********************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic doneClr;
  assign doneClr = regWr && regAddr == `OFF_CONTROL && regWdata[`CTL_DONE];

  sequence s_statusRead;
    regRd && regAddr == `OFF_STATUS;
  endsequence
  sequence s_sclLowTwice;
    !$past(sclIn) && !sclIn;
  endsequence

  // ********************
  // Assertions
  // ********************
  AST_STATUS_LOW: assert property (s_statusRead |=> regRdata[2:0] == 3'h0)
    else $error("status read with nonzero low bits");
  AST_RDATA_HOLD: assert property (!regRd |=> $stable(regRdata))
    else $error("read data changed without a read");
  AST_STRETCH_ON_LOW: assert property ($rose(sclOe) |-> s_sclLowTwice)
    else $error("clock stretch began while SCL high");
  AST_STRETCH_RELEASE: assert property ($fell(sclOe) |-> $past(doneClr) || $past(doneClr, 2))
    else $error("clock stretch ended without done clear");
  AST_SDA_ON_LOW: assert property ($changed(sdaOe) |-> !$past(sclIn, 2))
    else $error("SDA drive changed while SCL high");
  AST_WAKE_PULSE: assert property (wakeUp |=> !wakeUp)
    else $error("wake pulse longer than one cycle");
  AST_WAKE_ASLEEP: assert property (wakeUp |-> $past(deepSleep))
    else $error("wake pulse while awake");
  AST_START_PULSE: assert property (issueStart |=> !issueStart)
    else $error("start request longer than one cycle");
  AST_START_FREE: assert property (issueStart |-> sclIn && sdaIn)
    else $error("start request while bus busy");
  AST_OPEN_DRAIN: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("pin drive level not low");
endmodule : two_wire_slave_sva

// ---- testbench/bus_master_model.sv ----
// Behavioural two-wire bus master on open-drain lines
`timescale 1ns/1ps

module bus_master_model (
  input  wire logic sclLine, // Resolved SCL level
  input  wire logic sdaLine, // Resolved SDA level
  output logic      mScl,    // Master SCL, low pulls the line
  output logic      mSda     // Master SDA, low pulls the line
);
  // Quarter of the 160 ns bus clock period
  localparam int Q = 40;

  initial begin
    mScl = 1'b1;
    mSda = 1'b1;
  end

  // ********************
  // Bit level, SCL stands high between frames
  // ********************
  task automatic raiseScl();
    #Q mScl = 1'b1;
    wait (sclLine === 1'b1);
  endtask : raiseScl

  task automatic bitOut(input logic b);
    #Q mSda = b;
    raiseScl();
    #(2 * Q) mScl = 1'b0;
  endtask : bitOut

  task automatic bitIn(output logic b);
    #Q mSda = 1'b1;
    raiseScl();
    #Q b = sdaLine;
    #Q mScl = 1'b0;
  endtask : bitIn

  task automatic startCond();
    #(Q + 7) mSda = 1'b1;
    raiseScl();
    #(2 * Q) mSda = 1'b0;
    #(2 * Q) mScl = 1'b0;
  endtask : startCond

  task automatic stopCond();
    #Q mSda = 1'b0;
    raiseScl();
    #(2 * Q) mSda = 1'b1;
    #(2 * Q);
  endtask : stopCond

  // ********************
  // Byte level, MSB first
  // ********************
  task automatic writeByte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(ack);
  endtask : writeByte

  task automatic readByte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(nack);
  endtask : readByte
endmodule : bus_master_model

// ---- testbench/two_wire_slave_test.sv ----
// Self-checking bench for the two-wire slave
`timescale 1ns/1ps
`include "two_wire_slave_defs.svh"

module two_wire_slave_test;
  logic       clock, rst, regWr, regRd, deepSleep, arbLost, ack;
  logic       sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe, wakeUp, issueStart, mScl, mSda;
  logic [1:0] regAddr;
  logic [7:0] regWdata, regRdata, got;
  int         mismatches = 0, checked = 0, wakeCount = 0, startCount = 0;

  assign sclIn = mScl & ~sclOe;
  assign sdaIn = mSda & ~sdaOe;

  two_wire_slave i_dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .deepSleep(deepSleep),
    .arbLost(arbLost), .wakeUp(wakeUp), .issueStart(issueStart));
  bus_master_model i_master (.sclLine(sclIn), .sdaLine(sdaIn), .mScl(mScl), .mSda(mSda));

  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (wakeUp === 1'b1) wakeCount <= wakeCount + 1;
    if (issueStart === 1'b1) startCount <= startCount + 1;
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : regRead

  task automatic chkReg(input string name, input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    regRead(a, d);
    check(name, d, exp);
  endtask : chkReg

  task automatic ctrl(input logic [7:0] d);
    regWrite(`OFF_CONTROL, d);
  endtask : ctrl

  task automatic expectStatus(input logic [7:0] exp);
    logic [7:0] s;
    s = `ST_NONE;
    for (int n = 0; n < 20 && s === `ST_NONE; n++) regRead(`OFF_STATUS, s);
    check("status", s, exp);
  endtask : expectStatus

  task automatic addrByte(input logic [7:0] a, input logic exp);
    i_master.startCond();
    i_master.writeByte(a, ack);
    check("addrAck", {7'h0, ack}, {7'h0, exp});
  endtask : addrByte

  // ********************
  // Scenarios
  // ********************
  task automatic testReset();
    chkReg("data", `OFF_DATA, `RST_DATA);
    chkReg("status", `OFF_STATUS, `RST_STATUS);
    chkReg("ownAddr", `OFF_OWN_ADDR, `RST_OWN_ADDR);
    chkReg("control", `OFF_CONTROL, `RST_CONTROL);
    regWrite(`OFF_DATA, 8'h77);
    chkReg("collision", `OFF_CONTROL, 8'h08);
    chkReg("dataKept", `OFF_DATA, `RST_DATA);
    regWrite(`OFF_OWN_ADDR, 8'h55);
    ctrl(8'h44);
  endtask : testReset

  task automatic testTransmit();
    addrByte(8'h55, 1'b0);
    expectStatus(`ST_OWN_R);
    regWrite(`OFF_DATA, 8'ha5);
    ctrl(8'hc4);
    i_master.readByte(got, 1'b0);
    check("txByte", got, 8'ha5);
    expectStatus(`ST_TX_ACK);
    regWrite(`OFF_DATA, 8'h3c);
    ctrl(8'h84);
    i_master.readByte(got, 1'b0);
    check("lastByte", got, 8'h3c);
    expectStatus(`ST_TX_LAST_ACK);
    ctrl(8'hc4);
    i_master.readByte(got, 1'b1);
    check("released", got, 8'hff);
    i_master.stopCond();
    chkReg("idle", `OFF_STATUS, `ST_NONE);
  endtask : testTransmit

  task automatic testArbLost();
    @(posedge clock);
    arbLost <= 1'b1;
    addrByte(8'h55, 1'b0);
    expectStatus(`ST_ARB_R);
    @(posedge clock);
    arbLost <= 1'b0;
    regWrite(`OFF_DATA, 8'h81);
    ctrl(8'h84);
    i_master.readByte(got, 1'b1);
    check("arbByte", got, 8'h81);
    expectStatus(`ST_TX_NACK);
    ctrl(8'hc4);
    i_master.stopCond();
    chkReg("idle", `OFF_STATUS, `ST_NONE);
  endtask : testArbLost

  task automatic testGeneralCall();
    addrByte(8'h00, 1'b0);
    expectStatus(`ST_GEN_W);
    ctrl(8'hc4);
    i_master.writeByte(8'h12, ack);
    check("gcAck", {7'h0, ack}, 8'h00);
    expectStatus(`ST_GEN_RX_ACK);
    chkReg("gcData", `OFF_DATA, 8'h12);
    ctrl(8'h84);
    i_master.writeByte(8'h34, ack);
    check("gcNack", {7'h0, ack}, 8'h01);
    expectStatus(`ST_GEN_RX_NACK);
    ctrl(8'hc4);
    i_master.writeByte(8'h56, ack);
    check("gcIgnored", {7'h0, ack}, 8'h01);
    i_master.stopCond();
    chkReg("idle", `OFF_STATUS, `ST_NONE);
    regWrite(`OFF_OWN_ADDR, 8'h54);
    addrByte(8'h00, 1'b1);
    i_master.stopCond();
  endtask : testGeneralCall

  task automatic testAckEnable();
    ctrl(8'h04);
    addrByte(8'h54, 1'b1);
    i_master.stopCond();
    ctrl(8'h44);
    addrByte(8'h54, 1'b0);
    expectStatus(`ST_OWN_W);
    ctrl(8'hc4);
    i_master.writeByte(8'h9a, ack);
    check("ownAck", {7'h0, ack}, 8'h00);
    expectStatus(`ST_OWN_RX_ACK);
    chkReg("ownData", `OFF_DATA, 8'h9a);
    ctrl(8'hc4);
    i_master.stopCond();
    expectStatus(`ST_STOP);
    ctrl(8'he4);
    for (int n = 0; n < 40 && startCount == 0; n++) @(posedge clock);
    check("startReq", startCount[7:0], 8'h01);
    ctrl(8'h44);
  endtask : testAckEnable

  task automatic testSleep();
    @(posedge clock);
    deepSleep <= 1'b1;
    addrByte(8'h54, 1'b0);
    for (int n = 0; n < 40 && wakeCount == 0; n++) @(posedge clock);
    check("wake", wakeCount[7:0], 8'h01);
    repeat (4) @(posedge clock);
    #1 check("stretch", {7'h0, sclOe}, 8'h01);
    expectStatus(`ST_OWN_W);
    @(posedge clock);
    deepSleep <= 1'b0;
    ctrl(8'hc4);
    @(posedge clock);
    #1 check("unstretch", {7'h0, sclOe}, 8'h00);
    i_master.stopCond();
    expectStatus(`ST_STOP);
    ctrl(8'hc4);
  endtask : testSleep

  // ********************
  // Verdict and sequence
  // ********************
  task automatic summarize();
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial begin
    #1_500_000;
    mismatches++;
    summarize();
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    regAddr = 2'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    deepSleep = 1'b0;
    arbLost = 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    testReset();
    testTransmit();
    testArbLost();
    testGeneralCall();
    testAckEnable();
    testSleep();
    summarize();
  end
endmodule : two_wire_slave_test

bind two_wire_slave two_wire_slave_sva i_sva (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclIn),
  .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .deepSleep(deepSleep), .arbLost(arbLost), .wakeUp(wakeUp), .issueStart(issueStart));
